// *** hw/ued_core.sv ***
// Endpoint logic of a full-speed USB device: bulk OUT and iso pair.
// Assumes a packet decoder, a memory mover and a plain register port.
//
// Operation
// [R01] Bulk OUT NAKs until release written
// [R02] Next OUT+DATA ACKed, event and flag
// [R03] Start task moves packet to memory
// [R04] NAK further OUT+DATA while move pending
// [R05] Move done or release rearms endpoint
// [R06] Zero-length OUT packets are valid
// [R07] Per-endpoint enable and stall bits
// [R08] Iso pair uses addresses 0x88, 0x08
// [R09] Iso has no handshake, SOF each frame
// [R10] SOF retimed to 16 MHz fabric tick; the tick here is every 6th 100 MHz clock, about 16.7 MHz
// [R11] Each SOF bumps readable frame counter
// [R12] Disabled iso endpoints stay silent
// [R13] Iso buffer full or split, limits
// [R14] Loaded iso IN sends max-count bytes
// [R15] Empty iso IN: silence or ZLP
// [R16] Software keeps iso moves inside frame
// [R17] Iso memory buffers word aligned
// [R18] Iso OUT size register zero flag, size
// [R19] Iso OUT start uses pointer, max-count
// [R20] Bad iso CRC flagged at SOF
// [R21] Tasks, registers locked unless ready
// [R22] Ready flag with generic event
// [R23] Fixed bulk addresses 0x01 to 0x07
// [R24] Move no more than min length
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module ued_core import ued_pkg::*; (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset
  input wire logic [AW-1:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic ready_in, // Clocks and transceiver settled
  input wire ued_pkt_s pkt, // Decoded packet from the bus
  output ued_rsp_s rsp, // Answer to the packet
  output ued_dma_s dma, // Memory move request
  input wire logic dma_done, // Memory move finished
  input wire logic iso_in_filled, // Iso IN data loaded by mover
  output logic data_evt, // Data endpoint event
  output logic [7:0] out_done_evt, // OUT move done, per endpoint
  output logic iso_out_done_evt, // Iso OUT move done
  output logic usb_evt, // Generic USB event
  output logic sof_evt // SOF on fabric tick
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic en;
    logic lp;
    logic rdy;
    logic [1:0] cause;
    logic [7:0] dstat;
    logic [8:0] out_en;
    logic iso_in_en;
    logic [7:0] stall;
    logic split;
    logic zlp;
    logic [LEN_W-1:0] iso_in_cnt;
    logic [LEN_W-1:0] iso_out_cnt;
    logic [31:0] iso_out_ptr;
    logic [31:0] out_ptr;
    logic [LEN_W-1:0] out_cnt;
    logic [FRM_W-1:0] frame;
    logic iso_zero;
    logic [LEN_W-1:0] iso_size;
    logic crc_bad;
    logic in_full;
    logic iso_want;
    logic [7:1][LEN_W-1:0] rx_len;
    logic [7:1][31:0] ep_ptr;
    logic [7:1][LEN_W-1:0] ep_cnt;
    ued_dma_s dma;
    ued_rsp_s rsp;
    logic [31:0] rdata;
    logic dev;
    logic usb_evt;
    logic sof_pend;
    logic sof_evt;
    logic [2:0] div;
    logic [7:0] done_ev;
    logic iso_done;
  } ued_core_s;

  ued_core_s s_ff;
  ued_core_s nxt_s;

  logic acc_ok;
  logic wr_ok;
  logic [2:0] b_idx;
  logic [2:0] r_idx;
  logic [2:0] gsel;
  logic pk_bulk;
  logic dma_issue;
  logic tick;
  logic [LEN_W-1:0] iso_cap;
  logic [7:0] acc;
  logic [7:0] want;
  logic [7:0] rel;
  logic [7:0] start;
  logic [7:0] rx_ok;
  logic [7:0] grant;
  logic [7:0] done;

  // ********************************************************
  // Access gate and decode
  // ********************************************************
  // Tasks and locked registers only while enabled, ready, awake
  assign acc_ok = s_ff.en && s_ff.rdy && !s_ff.lp; // [R21]
  assign wr_ok = reg_wr && acc_ok; // [R21]
  assign b_idx = bulk_ep(pkt.ep); // [R23]
  assign r_idx = rel_ep(reg_addr);
  assign pk_bulk = pkt.valid && pkt.kind == PK_OUT && b_idx != 3'h0 &&
    pkt.crc_ok && s_ff.out_en[b_idx]; // [R07]
  assign gsel = pick(want);
  assign dma_issue = !s_ff.dma.valid && !s_ff.iso_want && |want;
  assign tick = (s_ff.div == 3'h0);
  assign iso_cap = s_ff.split ? ISO_MAX_SPLIT : ISO_MAX_FULL; // [R13]

  // ********************************************************
  // Bulk OUT endpoints 1 to 7
  // ********************************************************
  assign acc[0] = 1'b0;
  assign want[0] = 1'b0;
  assign rel[0] = 1'b0;
  assign start[0] = 1'b0;
  assign rx_ok[0] = 1'b0;
  assign grant[0] = 1'b0;
  assign done[0] = 1'b0;

  // One endpoint slice per number
  for (genvar i = 1; i < 8; i++) begin : g_ep
    assign rel[i] = wr_ok && r_idx == 3'(i); // [R05]
    assign start[i] = wr_ok && reg_addr == A_TASK && reg_wdata[i]; // [R03]
    assign rx_ok[i] = pk_bulk && b_idx == 3'(i) && !s_ff.stall[i] &&
      acc[i]; // [R02]
    assign grant[i] = dma_issue && gsel == 3'(i);
    assign done[i] = dma_done && s_ff.dma.valid && !s_ff.dma.iso &&
      s_ff.dma.ep == 3'(i);
    ued_ep_out u_ep (
      .clk_sys(clk_sys),
      .reset(reset),
      .release_wr(rel[i]),
      .start_dma(start[i]),
      .rx_ok(rx_ok[i]),
      .grant(grant[i]),
      .done(done[i]),
      .accept(acc[i]),
      .want(want[i])
    );
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rsp.valid = 1'b0;
    nxt_s.rdata = 32'h0;
    nxt_s.dev = 1'b0;
    nxt_s.usb_evt = 1'b0;
    nxt_s.sof_evt = 1'b0;
    nxt_s.done_ev = 8'h0;
    nxt_s.iso_done = 1'b0;
    nxt_s.div = (s_ff.div == DIV_LAST) ? 3'h0 : s_ff.div + 3'h1;

    // Register writes; clears come before the hardware sets below
    if (reg_wr && reg_addr == A_CTRL) begin
      nxt_s.en = reg_wdata[B_EN];
      nxt_s.lp = reg_wdata[B_LP];
    end
    if (reg_wr && reg_addr == A_CAUSE) begin
      nxt_s.cause = s_ff.cause & ~reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == A_DSTAT) begin
      nxt_s.dstat = s_ff.dstat & ~reg_wdata[7:0];
    end
    if (wr_ok) begin
      case (reg_addr)
        A_OUTEN: nxt_s.out_en = {reg_wdata[B_ISO], reg_wdata[7:1], 1'b0};
        A_INEN: nxt_s.iso_in_en = reg_wdata[B_ISO]; // [R12]
        A_STALL: nxt_s.stall = {reg_wdata[7:1], 1'b0}; // [R07]
        A_SPLIT: nxt_s.split = reg_wdata[0]; // [R13]
        A_INCFG: nxt_s.zlp = reg_wdata[0]; // [R15]
        A_INCNT: nxt_s.iso_in_cnt = reg_wdata[LEN_W-1:0];
        A_ISOPTR: nxt_s.iso_out_ptr = reg_wdata;
        A_ISOCNT: nxt_s.iso_out_cnt = reg_wdata[LEN_W-1:0];
        A_OUTPTR: nxt_s.out_ptr = reg_wdata;
        A_OUTCNT: nxt_s.out_cnt = reg_wdata[LEN_W-1:0];
        A_TASK: begin
          if (reg_wdata[B_ISO]) begin
            nxt_s.iso_want = 1'b1; // [R19]
          end
        end
        default: begin
        end
      endcase
    end

    // Capture pointer and max-count when an OUT move is started
    for (int i = 1; i < 8; i++) begin
      if (start[i]) begin
        nxt_s.ep_ptr[i] = s_ff.out_ptr; // [R03]
        nxt_s.ep_cnt[i] = s_ff.out_cnt;
      end
    end

    // Controller readiness
    if (!s_ff.en) begin
      nxt_s.rdy = 1'b0;
    end else if (ready_in && !s_ff.rdy) begin
      nxt_s.rdy = 1'b1; // [R22]
      nxt_s.cause[B_RDY] = 1'b1; // [R22]
      nxt_s.usb_evt = 1'b1; // [R22]
    end

    // Memory mover: iso first, then lowest bulk endpoint
    if (s_ff.dma.valid && dma_done) begin
      nxt_s.dma.valid = 1'b0;
      if (s_ff.dma.iso) begin
        nxt_s.iso_done = 1'b1;
      end else begin
        nxt_s.done_ev[s_ff.dma.ep] = 1'b1; // [R05]
      end
    end else if (!s_ff.dma.valid && s_ff.iso_want) begin
      // A start task in this very cycle stays pending
      nxt_s.iso_want = wr_ok && reg_addr == A_TASK && reg_wdata[B_ISO];
      nxt_s.dma = '{valid: 1'b1, iso: 1'b1, ep: 3'h0,
        addr: s_ff.iso_out_ptr, // [R19]
        len: minl(minl(s_ff.iso_size, iso_cap), s_ff.iso_out_cnt)}; // [R24]
    end else if (dma_issue) begin
      nxt_s.dma = '{valid: 1'b1, iso: 1'b0, ep: gsel,
        addr: s_ff.ep_ptr[gsel],
        len: minl(s_ff.rx_len[gsel], s_ff.ep_cnt[gsel])}; // [R24]
    end

    // Packets from the bus
    if (pk_bulk) begin
      nxt_s.rsp.valid = 1'b1;
      nxt_s.rsp.len = {LEN_W{1'b0}};
      if (s_ff.stall[b_idx]) begin
        nxt_s.rsp.code = RS_STALL; // [R07]
      end else if (acc[b_idx]) begin
        nxt_s.rsp.code = RS_ACK; // [R02] [R06]
        nxt_s.dev = 1'b1; // [R02]
        nxt_s.dstat[b_idx] = 1'b1; // [R02]
        nxt_s.rx_len[b_idx] = pkt.len; // [R06]
      end else begin
        nxt_s.rsp.code = RS_NAK; // [R01] [R04]
      end
    end
    if (pkt.valid && pkt.kind == PK_IN && pkt.ep == EP_ISO_IN &&
        s_ff.iso_in_en) begin // [R08] [R12]
      if (s_ff.in_full) begin
        nxt_s.rsp = '{valid: 1'b1, code: RS_DATA,
          len: minl(s_ff.iso_in_cnt, iso_cap)}; // [R14]
        nxt_s.in_full = 1'b0;
      end else if (s_ff.zlp) begin
        nxt_s.rsp = '{valid: 1'b1, code: RS_DATA,
          len: {LEN_W{1'b0}}}; // [R15]
      end
    end
    // Iso IN data loaded; a load wins over a send in the same cycle
    if (iso_in_filled) begin
      nxt_s.in_full = 1'b1; // [R14]
    end
    if (pkt.valid && pkt.kind == PK_OUT && pkt.ep == EP_ISO_OUT &&
        s_ff.out_en[B_ISO]) begin // [R08] [R09] [R12]
      nxt_s.iso_zero = (pkt.len == {LEN_W{1'b0}}); // [R18]
      nxt_s.iso_size = pkt.len; // [R18]
      nxt_s.crc_bad = !pkt.crc_ok; // [R20]
    end
    if (pkt.valid && pkt.kind == PK_SOF) begin
      nxt_s.frame = s_ff.frame + FRM_ONE; // [R11]
      if (s_ff.crc_bad) begin
        nxt_s.usb_evt = 1'b1; // [R20]
        nxt_s.cause[B_CRC] = 1'b1; // [R20]
        nxt_s.crc_bad = 1'b0;
      end
    end

    // SOF held until the next fabric tick
    nxt_s.sof_evt = s_ff.sof_pend && tick; // [R10]
    nxt_s.sof_pend = (s_ff.sof_pend && !tick) ||
      (pkt.valid && pkt.kind == PK_SOF); // [R10]

    // Read data, locked registers read zero
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: nxt_s.rdata = {30'h0, s_ff.lp, s_ff.en};
        A_CAUSE: nxt_s.rdata = 32'(s_ff.cause);
        A_DSTAT: nxt_s.rdata = 32'(s_ff.dstat);
        A_OUTEN: nxt_s.rdata = 32'(s_ff.out_en);
        A_INEN: nxt_s.rdata = 32'({s_ff.iso_in_en, 8'h0});
        A_STALL: nxt_s.rdata = 32'(s_ff.stall);
        A_FRAME: nxt_s.rdata = 32'(s_ff.frame); // [R11]
        A_SPLIT: nxt_s.rdata = 32'(s_ff.split);
        A_INCFG: nxt_s.rdata = 32'(s_ff.zlp);
        A_INCNT: nxt_s.rdata = 32'(s_ff.iso_in_cnt);
        A_ISOPTR: nxt_s.rdata = s_ff.iso_out_ptr;
        A_ISOCNT: nxt_s.rdata = 32'(s_ff.iso_out_cnt);
        A_OUTPTR: nxt_s.rdata = s_ff.out_ptr;
        A_OUTCNT: nxt_s.rdata = 32'(s_ff.out_cnt);
        A_ISOSIZE: nxt_s.rdata = 32'({s_ff.iso_zero, 5'h0,
          s_ff.iso_size}); // [R18]
        default: nxt_s.rdata = (r_idx != 3'h0) ?
          32'(s_ff.rx_len[r_idx]) : 32'h0;
      endcase
      if (!acc_ok && reg_addr != A_CTRL && reg_addr != A_CAUSE &&
          reg_addr != A_DSTAT) begin
        nxt_s.rdata = 32'h0; // [R21]
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign reg_rdata = s_ff.rdata;
  assign rsp = s_ff.rsp;
  assign dma = s_ff.dma;
  assign data_evt = s_ff.dev;
  assign out_done_evt = s_ff.done_ev;
  assign iso_out_done_evt = s_ff.iso_done;
  assign usb_evt = s_ff.usb_evt;
  assign sof_evt = s_ff.sof_evt;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  nak_gate_a: assert property ( // [R01]
    (pk_bulk && !s_ff.stall[b_idx] && !acc[b_idx]) |=>
      (rsp.valid && rsp.code == RS_NAK))
    else $error("closed endpoint did not NAK");
  ack_event_a: assert property ( // [R02]
    (pk_bulk && !s_ff.stall[b_idx] && acc[b_idx]) |=>
      (rsp.code == RS_ACK && data_evt && s_ff.dstat[$past(b_idx)]))
    else $error("accepted packet missing ACK or event");
  hold_nak_a: assert property ( // [R04]
    (pk_bulk && !s_ff.stall[b_idx] && acc[b_idx] && !rel[b_idx]) |=>
      !acc[$past(b_idx)])
    else $error("endpoint kept accepting during move");
  release_opens_a: assert property ( // [R05]
    (wr_ok && r_idx != 3'h0) |=> acc[$past(r_idx)])
    else $error("release did not open endpoint");
  off_silent_a: assert property ( // [R12]
    (pkt.valid && pkt.kind == PK_OUT && pkt.ep == EP_ISO_OUT &&
     !s_ff.out_en[B_ISO]) |=> $stable(s_ff.iso_size) && !rsp.valid)
    else $error("disabled iso OUT reacted");
  frame_step_a: assert property ( // [R11]
    (pkt.valid && pkt.kind == PK_SOF) |=>
      s_ff.frame == $past(s_ff.frame) + FRM_ONE)
    else $error("frame counter did not step");
  sof_retime_a: assert property ( // [R10]
    (pkt.valid && pkt.kind == PK_SOF) |-> ##[1:7] sof_evt)
    else $error("SOF not passed to fabric");
  iso_zlp_a: assert property ( // [R15]
    (pkt.valid && pkt.kind == PK_IN && pkt.ep == EP_ISO_IN &&
     s_ff.iso_in_en && !s_ff.in_full && s_ff.zlp) |=>
      (rsp.valid && rsp.code == RS_DATA && rsp.len == 11'h000))
    else $error("empty iso IN did not send ZLP");
  crc_flag_a: assert property ( // [R20]
    (pkt.valid && pkt.kind == PK_SOF && s_ff.crc_bad) |=>
      (usb_evt && s_ff.cause[B_CRC]))
    else $error("iso CRC error not flagged at SOF");
  size_zero_a: assert property ( // [R18]
    (pkt.valid && pkt.kind == PK_OUT && pkt.ep == EP_ISO_OUT &&
     s_ff.out_en[B_ISO]) |=>
      s_ff.iso_zero == ($past(pkt.len) == 11'h000))
    else $error("iso size zero flag wrong");
  locked_write_a: assert property ( // [R21]
    (reg_wr && !acc_ok && reg_addr == A_STALL) |=> $stable(s_ff.stall))
    else $error("locked register took a write");

  bulk_ack_c: cover property (rsp.valid && rsp.code == RS_ACK);
  bulk_done_c: cover property (|out_done_evt);
  iso_data_c: cover property (rsp.valid && rsp.code == RS_DATA &&
    rsp.len != 11'h000);
  crc_seen_c: cover property (usb_evt && s_ff.cause[B_CRC]);

endmodule : ued_core

// *** hw/ued_ep_out.sv ***
// One bulk OUT endpoint: NAK/ACK gating around the memory move.
// Assumes the core only raises rx_ok while accept is high.
`timescale 1ns/10ps
module ued_ep_out import ued_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic release_wr, // Write to release size register
  input wire logic start_dma, // Start OUT DMA task
  input wire logic rx_ok, // OUT+DATA acknowledged here
  input wire logic grant, // Mover taken for this endpoint
  input wire logic done, // Mover finished this endpoint
  output logic accept, // Next OUT+DATA gets ACK
  output logic want // Packet held and move requested
);

  typedef struct packed {
    ued_ep_e st;
    logic want;
  } ued_ep_s;

  ued_ep_s s_ff;
  ued_ep_s nxt_s;

  // Next state of the endpoint
  always_comb begin
    nxt_s = s_ff;
    case (s_ff.st)
      EP_NAK: begin
        nxt_s.st = EP_NAK; // [R01]
      end
      EP_ARMED: begin
        if (rx_ok) begin
          nxt_s.st = EP_HELD; // [R04]
        end
      end
      EP_HELD: begin
        if (grant) begin
          nxt_s.st = EP_MOVE;
          nxt_s.want = 1'b0;
        end
      end
      EP_MOVE: begin
        if (done) begin
          nxt_s.st = EP_ARMED; // [R05]
        end
      end
      default: begin
        nxt_s.st = EP_NAK;
      end
    endcase
    if (start_dma) begin
      nxt_s.want = 1'b1; // [R03]
    end
    if (release_wr) begin
      nxt_s.st = EP_ARMED; // [R01] [R05]
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_ff <= '{st: EP_NAK, want: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign accept = (s_ff.st == EP_ARMED);
  assign want = s_ff.want && (s_ff.st == EP_HELD);

  // ********************************************************
  // Checks
  // ********************************************************
  done_rearms_a: assert property (@(posedge clk_sys) // [R05]
    disable iff (reset) (s_ff.st == EP_MOVE && done) |=> accept)
    else $error("endpoint not rearmed after move");

endmodule : ued_ep_out

// *** hw/ued_pkg.sv ***
// Shared constants, types and helpers of the USB device endpoint logic.
// Assumes one 100 MHz clock and a packet decoder in front of the block.
package ued_pkg;

  // ********************************************************
  // Clocking and widths
  // ********************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FAB_MHZ = 16;
  localparam int unsigned FAB_DIV = CLK_MHZ / FAB_MHZ;
  localparam logic [2:0] DIV_LAST = 3'(FAB_DIV - 1);
  localparam int unsigned LEN_W = 11;
  localparam int unsigned FRM_W = 11;
  localparam int unsigned AW = 8;
  localparam logic [FRM_W-1:0] FRM_ONE = 11'h001;

  // ********************************************************
  // Endpoint addresses and iso buffer limits
  // ********************************************************
  localparam logic [7:0] EP_ISO_IN = 8'h88;
  localparam logic [7:0] EP_ISO_OUT = 8'h08;
  localparam logic [7:0] EP_OUT_FIRST = 8'h01;
  localparam logic [7:0] EP_OUT_LAST = 8'h07;
  localparam logic [7:0] EP_IN_FIRST = 8'h81;
  localparam logic [LEN_W-1:0] ISO_MAX_FULL = 11'h3ff;
  localparam logic [LEN_W-1:0] ISO_MAX_SPLIT = 11'h1ff;

  // ********************************************************
  // Register offsets and bit positions
  // ********************************************************
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_TASK = 8'h04;
  localparam logic [AW-1:0] A_CAUSE = 8'h08;
  localparam logic [AW-1:0] A_DSTAT = 8'h0c;
  localparam logic [AW-1:0] A_OUTEN = 8'h10;
  localparam logic [AW-1:0] A_INEN = 8'h14;
  localparam logic [AW-1:0] A_STALL = 8'h18;
  localparam logic [AW-1:0] A_FRAME = 8'h1c;
  localparam logic [AW-1:0] A_SPLIT = 8'h20;
  localparam logic [AW-1:0] A_INCFG = 8'h24;
  localparam logic [AW-1:0] A_INCNT = 8'h28;
  localparam logic [AW-1:0] A_ISOPTR = 8'h2c;
  localparam logic [AW-1:0] A_ISOCNT = 8'h30;
  localparam logic [AW-1:0] A_OUTPTR = 8'h34;
  localparam logic [AW-1:0] A_OUTCNT = 8'h38;
  localparam logic [AW-1:0] A_ISOSIZE = 8'h3c;
  localparam logic [AW-1:0] A_REL = 8'h40;
  localparam int unsigned B_EN = 0;
  localparam int unsigned B_LP = 1;
  localparam int unsigned B_CRC = 0;
  localparam int unsigned B_RDY = 1;
  localparam int unsigned B_ISO = 8;
  localparam int unsigned B_ZERO = 16;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {PK_OUT, PK_IN, PK_SOF} ued_pkt_e;
  typedef enum logic [1:0] {RS_ACK, RS_NAK, RS_STALL, RS_DATA} ued_rsp_e;
  typedef enum logic [1:0] {EP_NAK, EP_ARMED, EP_HELD, EP_MOVE} ued_ep_e;
  typedef struct packed {
    logic valid; ued_pkt_e kind; logic [7:0] ep;
    logic [LEN_W-1:0] len; logic crc_ok;
  } ued_pkt_s;
  typedef struct packed {
    logic valid; ued_rsp_e code; logic [LEN_W-1:0] len;
  } ued_rsp_s;
  typedef struct packed {
    logic valid; logic iso; logic [2:0] ep;
    logic [31:0] addr; logic [LEN_W-1:0] len;
  } ued_dma_s;

  // ********************************************************
  // Helpers
  // ********************************************************
  // Bulk OUT endpoint number of a USB address, zero if none
  function automatic logic [2:0] bulk_ep(input logic [7:0] a);
    bulk_ep = (a >= EP_OUT_FIRST && a <= EP_OUT_LAST) ? a[2:0] : 3'h0;
  endfunction : bulk_ep

  // Endpoint number of a release-size register address
  function automatic logic [2:0] rel_ep(input logic [AW-1:0] a);
    rel_ep = (a[AW-1:5] == A_REL[AW-1:5] && a[1:0] == 2'h0) ?
      a[4:2] : 3'h0;
  endfunction : rel_ep

  // Smaller of two lengths
  function automatic logic [LEN_W-1:0] minl(input logic [LEN_W-1:0] a,
                                          input logic [LEN_W-1:0] b);
    minl = (a < b) ? a : b;
  endfunction : minl

  // Lowest endpoint that asks for the mover
  function automatic logic [2:0] pick(input logic [7:0] w);
    pick = 3'h0;
    for (int i = 7; i >= 1; i--) begin
      if (w[i]) begin
        pick = 3'(i);
      end
    end
  endfunction : pick

endpackage : ued_pkg

// *** test/ued_core_bench.sv ***
// Self-checking bench of the endpoint logic through registers and packets.
// Assumes the host model stands on the packet and mover side.
`timescale 1ns/10ps
module ued_core_bench import ued_pkg::*;;
  logic clk_sys, reset, reg_wr, reg_rd, ready_in, data_evt;
  logic [AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic dma_done, iso_in_filled, iso_out_done_evt, usb_evt, sof_evt;
  logic [7:0] out_done_evt;
  ued_pkt_s pkt;
  ued_rsp_s rsp;
  ued_dma_s dma;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  ued_core dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ready_in(ready_in), .pkt(pkt), .rsp(rsp),
    .dma(dma), .dma_done(dma_done), .iso_in_filled(iso_in_filled),
    .data_evt(data_evt), .out_done_evt(out_done_evt),
    .iso_out_done_evt(iso_out_done_evt), .usb_evt(usb_evt),
    .sof_evt(sof_evt));
  ued_host_model host (.clk_sys(clk_sys), .pkt(pkt), .dma(dma),
    .dma_done(dma_done), .iso_in_filled(iso_in_filled));

  // Clock and cycle ceiling
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Register port cycles
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd

  // Packet and the answer one cycle later
  task automatic pk(input ued_pkt_e k, input logic [7:0] ep,
      input logic [LEN_W-1:0] n, input logic ok, input logic ev,
      input ued_rsp_e ec);
    host.send(k, ep, n, ok);
    #1 chk({31'h0, rsp.valid}, {31'h0, ev});
    if (ev) chk({30'h0, rsp.code}, {30'h0, ec});
  endtask : pk

  // Bounded wait for an output pulse or level
  task automatic wait_for(input int s);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 20 && !hit; i++) begin
      #1 hit = (s == 0) ? sof_evt : (s == 1) ? usb_evt :
        (s == 2) ? out_done_evt[1] : (s == 3) ? dma.valid :
        iso_out_done_evt;
      if (!hit) @(posedge clk_sys);
    end
    chk({31'h0, hit}, 32'h1);
  endtask : wait_for

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ready_in = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    // Locked until enabled and ready, then bulk traffic
    wr(A_OUTEN, 32'h102);
    ready_in <= 1'b1;
    wr(A_CTRL, 32'h1);
    rd(A_CAUSE, 32'h2);
    rd(A_OUTEN, 32'h0);
    rd(8'hfc, 32'h0);
    wr(A_OUTEN, 32'h102);
    wr(A_INEN, 32'h100);
    pk(PK_OUT, 8'h01, 11'h008, 1'b1, 1'b1, RS_NAK);
    wr(A_REL + 8'h04, 32'h0);
    pk(PK_OUT, 8'h01, 11'h008, 1'b1, 1'b1, RS_ACK);
    chk({31'h0, data_evt}, 32'h1);
    rd(A_DSTAT, 32'h2);
    pk(PK_OUT, 8'h01, 11'h008, 1'b1, 1'b1, RS_NAK);
    wr(A_OUTPTR, 32'h100);
    wr(A_OUTCNT, 32'h4);
    wr(A_TASK, 32'h2);
    wait_for(3);
    chk(dma.addr, 32'h100);
    chk({21'h0, dma.len}, 32'h4);
    wait_for(2);
    pk(PK_OUT, 8'h01, 11'h000, 1'b1, 1'b1, RS_ACK);
    wr(A_STALL, 32'h2);
    pk(PK_OUT, 8'h01, 11'h008, 1'b1, 1'b1, RS_STALL);
    pk(PK_OUT, 8'h02, 11'h008, 1'b1, 1'b0, RS_NAK);
    $display("test bulk done");
    // Iso pair, split buffer, frame counting and CRC flag
    host.lag = 3'h6;
    pk(PK_IN, 8'h88, 11'h000, 1'b1, 1'b0, RS_DATA);
    wr(A_INCFG, 32'h1);
    pk(PK_IN, 8'h88, 11'h000, 1'b1, 1'b1, RS_DATA);
    chk({21'h0, rsp.len}, 32'h0);
    wr(A_INCNT, 32'h10);
    host.fill();
    pk(PK_IN, 8'h88, 11'h000, 1'b1, 1'b1, RS_DATA);
    chk({21'h0, rsp.len}, 32'h10);
    wr(A_SPLIT, 32'h1);
    wr(A_INCNT, 32'h3ff);
    host.fill();
    pk(PK_IN, 8'h88, 11'h000, 1'b1, 1'b1, RS_DATA);
    chk({21'h0, rsp.len}, 32'h1ff);
    pk(PK_OUT, 8'h08, 11'h000, 1'b1, 1'b0, RS_ACK);
    rd(A_ISOSIZE, 32'h10000);
    pk(PK_OUT, 8'h08, 11'h005, 1'b1, 1'b0, RS_ACK);
    rd(A_ISOSIZE, 32'h5);
    wr(A_ISOPTR, 32'h200);
    wr(A_ISOCNT, 32'h8);
    wr(A_TASK, 32'h100);
    wait_for(3);
    chk({dma.iso, dma.addr[30:0]}, 32'h80000200);
    chk({21'h0, dma.len}, 32'h5);
    wait_for(4);
    pk(PK_OUT, 8'h08, 11'h003, 1'b0, 1'b0, RS_ACK);
    pk(PK_SOF, 8'h00, 11'h000, 1'b1, 1'b0, RS_ACK);
    wait_for(1);
    wait_for(0);
    rd(A_CAUSE, 32'h3);
    rd(A_FRAME, 32'h1);
    wr(A_OUTEN, 32'h2);
    pk(PK_OUT, 8'h08, 11'h007, 1'b1, 1'b0, RS_ACK);
    rd(A_ISOSIZE, 32'h3);
    $display("test iso done");
    // Low power locks the frame counter and the stall register
    wr(A_CTRL, 32'h3);
    rd(A_FRAME, 32'h0);
    wr(A_STALL, 32'h0);
    wr(A_CTRL, 32'h1);
    rd(A_STALL, 32'h2);
    $display("test lock done");
    end_sim();
  end
endmodule : ued_core_bench

// *** test/ued_host_model.sv ***
// Far side model: a full-speed host sending packets, and the memory mover.
// Assumes the bench calls send and fill through the instance name.
`timescale 1ns/10ps
module ued_host_model import ued_pkg::*; (
  input wire logic clk_sys, // System clock
  output ued_pkt_s pkt, // Decoded packet towards the device
  input wire ued_dma_s dma, // Move request from the device
  output logic dma_done, // Move finished pulse
  output logic iso_in_filled // Iso IN data loaded pulse
);
  // ********************************************************
  // Mover
  // ********************************************************
  logic [2:0] cnt_ff;
  logic [2:0] lag;
  initial begin
    pkt = '0;
    dma_done = 1'b0;
    iso_in_filled = 1'b0;
    cnt_ff = 3'h0;
    lag = 3'h1;
  end

  // Finishes a held request after lag cycles, prompt or slow
  always @(posedge clk_sys) begin
    dma_done <= 1'b0;
    if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
      dma_done <= (cnt_ff == 3'h1);
    end else if (dma.valid && !dma_done) begin
      cnt_ff <= lag;
    end
  end

  // ********************************************************
  // Host side
  // ********************************************************
  // One packet for one cycle, then the fields are scrambled
  task automatic send(input ued_pkt_e k, input logic [7:0] ep,
                      input logic [LEN_W-1:0] n, input logic ok);
    @(posedge clk_sys);
    pkt <= '{1'b1, k, ep, n, ok};
    @(posedge clk_sys);
    pkt <= '{1'b0, k, ~ep, ~n, ~ok};
  endtask : send

  // Iso IN buffer loaded by the mover
  task automatic fill();
    @(posedge clk_sys);
    iso_in_filled <= 1'b1;
    @(posedge clk_sys);
    iso_in_filled <= 1'b0;
  endtask : fill
endmodule : ued_host_model
